// ### inc/dbe_pkg.sv
// Purpose: shared constants and types of the dynamic bass enhancer
// Assumes: 16-bit signed audio, AHB-Lite register access
// Notes: byte addresses, field positions, reset values, timing counts
package dbe_pkg;
	// ----------------------------------------
	// register byte addresses
	// ----------------------------------------
	localparam logic [7:0] DBE_CTRL_A = 8'h00;
	localparam logic [7:0] DBE_STR_A = 8'h04;
	localparam logic [7:0] DBE_HARM_A = 8'h08;
	localparam logic [7:0] DBE_CF_A = 8'h0c;
	localparam logic [7:0] DBE_LIM_A = 8'h10;
	localparam logic [7:0] DBE_LVL0_A = 8'h14;
	localparam logic [7:0] DBE_LVL1_A = 8'h18;
	localparam logic [7:0] DBE_STAT_A = 8'h1c;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int DBE_CTRL_EN_BIT = 0;
	localparam int DBE_CTRL_MIX_BIT = 1;
	localparam int DBE_STAT_LIM_BIT = 2;
	localparam int DBE_STAT_GR_LSB = 8;
	// ----------------------------------------
	// reset values and ranges
	// ----------------------------------------
	localparam logic [7:0] DBE_STR_OFF = 8'h00;
	localparam logic [7:0] DBE_STR_MED = 8'h80;
	localparam logic [6:0] DBE_HARM_OFF = 7'h00;
	localparam logic [6:0] DBE_HARM_HALF = 7'h32;
	localparam logic [6:0] DBE_HARM_FULL = 7'h64;
	localparam logic [8:0] DBE_CF_DEF = 9'h05a;
	localparam logic [8:0] DBE_CF_MIN = 9'h014;
	localparam logic [8:0] DBE_CF_MAX = 9'h12c;
	localparam logic [5:0] DBE_LIM_DEF = 6'h00;
	localparam logic [5:0] DBE_LIM_MAX = 6'h20;
	localparam logic [7:0] DBE_LVL_UNITY = 8'h40;
	localparam logic [15:0] DBE_FULL = 16'h7fff;
	// ----------------------------------------
	// timing and scaling
	// ----------------------------------------
	localparam int DBE_FS_HZ = 48000;
	localparam int DBE_TWO_PI_Q16 = 411775;
	localparam logic [3:0] DBE_CF_K = 4'(DBE_TWO_PI_Q16 / DBE_FS_HZ);
	localparam logic [8:0] DBE_XF_FULL = 9'h100;
	localparam logic [7:0] DBE_GR_UP = 8'h08;
	typedef enum {DBE_BYPASS, DBE_FADE_IN, DBE_ACTIVE, DBE_FADE_OUT} dbe_fade_t;
endpackage

// ### inc/dbe_dyn_if.sv
// Purpose: link between sample path and dynamics unit
// Assumes: one sample strobe per audio sample
// Notes: gain is unsigned q1.8, 0x100 is unity
`timescale 1ns/1ps
`default_nettype none
interface dbe_dyn_if;
	logic stb;
	logic signed [15:0] x;
	logic [7:0] strength;
	logic [15:0] limit;
	logic lim_on;
	logic [8:0] gain;
	logic [7:0] gr;
	logic limiting;
	modport top (output stb, x, strength, limit, lim_on, input gain, gr, limiting);
	modport dyn (input stb, x, strength, limit, lim_on, output gain, gr, limiting);
endinterface
`default_nettype wire

// ### verilog/dbe_dyn.sv
// Purpose: envelope, level-dependent gain and limiter gain reduction
// Assumes: x is the low-passed subwoofer sample
// Notes: gain lags the sample path by two samples
`timescale 1ns/1ps
`default_nettype none
module dbe_dyn
	import dbe_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	dbe_dyn_if.dyn dif
);
	logic [15:0] env_r;
	logic [7:0] gr_r;
	logic [8:0] gain_r;
	logic lim_r;
	logic [15:0] ax;
	logic [7:0] boost;
	logic [8:0] raw;
	logic [8:0] gain_nxt;
	logic [16:0] peak;
	logic near;

	assign ax = dif.x[15] ? 16'(-dif.x) : 16'(dif.x);
	// quiet bass gets more boost than loud bass
	assign boost = 8'((24'(dif.strength) * 24'(DBE_FULL - env_r)) >> 15);
	assign raw = 9'h100 + 9'(boost);
	assign gain_nxt = 9'((18'(raw) * 18'(10'h100 - 10'(gr_r))) >> 8);
	assign peak = 17'((25'(env_r) * 25'(gain_r)) >> 8);
	assign near = dif.lim_on && (peak > 17'(dif.limit - (dif.limit >> 3)));

	// ----------------------------------------
	// envelope: instant attack, slow decay
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			env_r <= 16'h0000;
		end else if (dif.stb) begin
			if (ax > env_r) begin
				env_r <= ax;
			end else begin
				env_r <= env_r - (env_r >> 8);
			end
		end
	end

	// ----------------------------------------
	// gain reduction near the amplitude limit
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gr_r <= 8'h00;
			lim_r <= 1'b0;
		end else if (dif.stb) begin
			lim_r <= near;
			if (near) begin
				gr_r <= (gr_r > 8'hff - DBE_GR_UP) ? 8'hff : gr_r + DBE_GR_UP;
			end else if (gr_r != 8'h00) begin
				gr_r <= gr_r - 8'h01;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gain_r <= 9'h100;
		end else if (dif.stb) begin
			gain_r <= gain_nxt;
		end
	end

	assign dif.gain = gain_r;
	assign dif.gr = gr_r;
	assign dif.limiting = lim_r;
endmodule
`default_nettype wire

// ### verilog/dbe_top.sv
// Purpose: dynamic bass enhancer in the subwoofer path, AHB-Lite registers
// Assumes: sample_stb one cycle per sample, inputs synchronous to hclk
// Notes: reads take one wait state, writes none
//
// Functional notes
// - enhancement works on the subwoofer signal, not the main channels
// - option mixes enhanced bass back onto left and right
// - combines dynamic amplification with added harmonics
// - strength off to max; off when disabled, medium when enabled
// - harmonic share 0 to 100 percent; 0 disabled, 50 enabled
// - center frequency 20 to 300 Hz, default 90 Hz
// - amplitude limit -32 to 0 dBFS; 0 dBFS means no limiting
// - two subwoofer level sets, one for off, one for on
// - output level watched; gain drops near the limit to avoid clipping
// - quieter bass receives relatively more gain than louder bass
// - harmonics of low components added in the set proportion
// - subwoofer signal is average of left and right
// - enabling or disabling crossfades without clicks; on disable, strength and harmonic share drop to off before the fade-out
//
// Our own choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dbe_top
	import dbe_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic sample_stb,
	input wire logic signed [15:0] in_l,
	input wire logic signed [15:0] in_r,
	output logic signed [15:0] out_l,
	output logic signed [15:0] out_r,
	output logic signed [15:0] out_sub,
	output logic out_valid
);
	// ----------------------------------------
	// saturation to 16 bits
	// ----------------------------------------
	function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
		logic signed [15:0] r;
		if (v > 32'sd32767) begin
			r = 16'sh7fff;
		end else if (v < -32'sd32768) begin
			r = -16'sh8000;
		end else begin
			r = 16'(v);
		end
		return r;
	endfunction

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic en_r;
	logic mix_r;
	logic [7:0] str_r;
	logic [6:0] harm_r;
	logic [8:0] cf_r;
	logic [5:0] lim_r;
	logic [7:0] lvl0_r;
	logic [7:0] lvl1_r;
	logic ap_wr_r;
	logic ap_hit_r;
	logic [7:0] ap_addr_r;
	logic rd_pend_r;
	logic [31:0] hrdata_r;
	logic hready_r;
	logic acc;
	logic [31:0] rd_val;
	logic signed [15:0] lp_r;
	logic [15:0] dc_r;
	logic [8:0] xf_r;
	dbe_fade_t fade_r;
	logic signed [15:0] out_l_r;
	logic signed [15:0] out_r_r;
	logic signed [15:0] out_sub_r;
	logic valid_r;
	logic signed [16:0] sum;
	logic signed [15:0] avg;
	logic [12:0] coef;
	logic signed [31:0] step;
	logic [15:0] alp;
	logic signed [31:0] hsig;
	logic signed [31:0] hmix;
	logic signed [31:0] amp;
	logic [15:0] lim_lin;
	logic signed [31:0] enh;
	logic signed [31:0] wet;
	logic signed [31:0] dry;
	logic signed [31:0] sub;
	logic signed [15:0] sub16;

	dbe_dyn_if dif();

	dbe_dyn u_dyn (
		.hclk(hclk),
		.hresetn(hresetn),
		.dif(dif)
	);

	// ----------------------------------------
	// bus address phase
	// ----------------------------------------
	assign acc = hsel && hready && htrans[1];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_r <= 1'b0;
			ap_hit_r <= 1'b0;
			ap_addr_r <= 8'h00;
		end else begin
			ap_wr_r <= acc && hwrite;
			if (acc) begin
				ap_addr_r <= haddr[7:0];
				ap_hit_r <= (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
			end
		end
	end

	// one wait state on reads so a preceding write is visible
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_pend_r <= 1'b0;
			hready_r <= 1'b1;
			hrdata_r <= 32'h00000000;
		end else begin
			rd_pend_r <= acc && !hwrite;
			hready_r <= !(acc && !hwrite);
			if (rd_pend_r) begin
				hrdata_r <= rd_val;
			end
		end
	end

	// ----------------------------------------
	// read decode
	// ----------------------------------------
	always_comb begin
		rd_val = 32'h00000000;
		if (!ap_hit_r) begin
			rd_val = 32'h00000000;
		end else if (ap_addr_r == DBE_CTRL_A) begin
			rd_val[DBE_CTRL_EN_BIT] = en_r;
			rd_val[DBE_CTRL_MIX_BIT] = mix_r;
		end else if (ap_addr_r == DBE_STR_A) begin
			rd_val[7:0] = str_r;
		end else if (ap_addr_r == DBE_HARM_A) begin
			rd_val[6:0] = harm_r;
		end else if (ap_addr_r == DBE_CF_A) begin
			rd_val[8:0] = cf_r;
		end else if (ap_addr_r == DBE_LIM_A) begin
			rd_val[5:0] = lim_r;
		end else if (ap_addr_r == DBE_LVL0_A) begin
			rd_val[7:0] = lvl0_r;
		end else if (ap_addr_r == DBE_LVL1_A) begin
			rd_val[7:0] = lvl1_r;
		end else if (ap_addr_r == DBE_STAT_A) begin
			rd_val[1:0] = 2'(fade_r);
			rd_val[DBE_STAT_LIM_BIT] = dif.limiting;
			rd_val[DBE_STAT_GR_LSB +: 8] = dif.gr;
		end
	end

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en_r <= 1'b0;
			mix_r <= 1'b0;
		end else if (ap_wr_r && ap_hit_r && ap_addr_r == DBE_CTRL_A) begin
			en_r <= hwdata[DBE_CTRL_EN_BIT];
			mix_r <= hwdata[DBE_CTRL_MIX_BIT];
		end
	end

	// strength and harmonic share reload their defaults on enable change
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			str_r <= DBE_STR_OFF;
			harm_r <= DBE_HARM_OFF;
		end else if (ap_wr_r && ap_hit_r) begin
			if (ap_addr_r == DBE_CTRL_A && hwdata[DBE_CTRL_EN_BIT] != en_r) begin
				str_r <= hwdata[DBE_CTRL_EN_BIT] ? DBE_STR_MED : DBE_STR_OFF;
				harm_r <= hwdata[DBE_CTRL_EN_BIT] ? DBE_HARM_HALF : DBE_HARM_OFF;
			end else if (ap_addr_r == DBE_STR_A) begin
				str_r <= hwdata[7:0];
			end else if (ap_addr_r == DBE_HARM_A) begin
				harm_r <= (hwdata[6:0] > DBE_HARM_FULL) ? DBE_HARM_FULL : hwdata[6:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cf_r <= DBE_CF_DEF;
			lim_r <= DBE_LIM_DEF;
		end else if (ap_wr_r && ap_hit_r) begin
			if (ap_addr_r == DBE_CF_A) begin
				if (hwdata[8:0] > DBE_CF_MAX || hwdata[31:9] != 23'h0) begin
					cf_r <= DBE_CF_MAX;
				end else if (hwdata[8:0] < DBE_CF_MIN) begin
					cf_r <= DBE_CF_MIN;
				end else begin
					cf_r <= hwdata[8:0];
				end
			end else if (ap_addr_r == DBE_LIM_A) begin
				lim_r <= (hwdata[5:0] > DBE_LIM_MAX) ? DBE_LIM_MAX : hwdata[5:0];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lvl0_r <= DBE_LVL_UNITY;
			lvl1_r <= DBE_LVL_UNITY;
		end else if (ap_wr_r && ap_hit_r) begin
			if (ap_addr_r == DBE_LVL0_A) begin
				lvl0_r <= hwdata[7:0];
			end else if (ap_addr_r == DBE_LVL1_A) begin
				lvl1_r <= hwdata[7:0];
			end
		end
	end

	// ----------------------------------------
	// subwoofer sum and low-pass
	// ----------------------------------------
	assign sum = 17'(in_l) + 17'(in_r);
	assign avg = sum[16:1];
	assign coef = 13'(cf_r) * 13'(DBE_CF_K);
	assign step = (32'(32'(avg) - 32'(lp_r)) * $signed(32'(coef))) >>> 16;
	assign alp = lp_r[15] ? 16'(-lp_r) : 16'(lp_r);

	// ----------------------------------------
	// harmonics: rectified bass minus its mean
	// ----------------------------------------
	assign hsig = $signed(32'(alp)) - $signed(32'(dc_r));
	assign hmix = (hsig * $signed(32'(harm_r)) * 32'sd41) >>> 12;

	// ----------------------------------------
	// dynamic gain and limit clamp
	// ----------------------------------------
	assign amp = (32'(lp_r) * $signed(32'(dif.gain))) >>> 8;
	assign lim_lin = DBE_FULL >> ((10'(lim_r) * 10'd11) >> 6);
	always_comb begin
		enh = amp + hmix;
		if (enh > $signed(32'(lim_lin))) begin
			enh = $signed(32'(lim_lin));
		end else if (enh < -$signed(32'(lim_lin))) begin
			enh = -$signed(32'(lim_lin));
		end
	end

	// ----------------------------------------
	// parameter sets and crossfade
	// ----------------------------------------
	assign wet = (enh * $signed(32'(lvl1_r))) >>> 6;
	assign dry = (32'(lp_r) * $signed(32'(lvl0_r))) >>> 6;
	assign sub = dry + (((wet - dry) * $signed(32'(xf_r))) >>> 8);
	assign sub16 = sat16(sub);

	assign dif.stb = sample_stb;
	assign dif.x = lp_r;
	assign dif.strength = str_r;
	assign dif.limit = lim_lin;
	assign dif.lim_on = (lim_r != DBE_LIM_DEF);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lp_r <= 16'sh0000;
			dc_r <= 16'h0000;
		end else if (sample_stb) begin
			lp_r <= sat16(32'(lp_r) + step);
			dc_r <= 16'($signed(32'(dc_r)) + (hsig >>> 6));
		end
	end

	// fade ramps one step per sample between bypass and active
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fade_r <= DBE_BYPASS;
			xf_r <= 9'h000;
		end else if (sample_stb) begin
			case (fade_r)
				DBE_BYPASS: begin
					if (en_r) begin
						fade_r <= DBE_FADE_IN;
					end
				end
				DBE_FADE_IN: begin
					if (!en_r) begin
						fade_r <= DBE_FADE_OUT;
					end else if (xf_r == DBE_XF_FULL) begin
						fade_r <= DBE_ACTIVE;
					end else begin
						xf_r <= xf_r + 9'h001;
					end
				end
				DBE_ACTIVE: begin
					if (!en_r) begin
						fade_r <= DBE_FADE_OUT;
					end
				end
				DBE_FADE_OUT: begin
					if (en_r) begin
						fade_r <= DBE_FADE_IN;
					end else if (xf_r == 9'h000) begin
						fade_r <= DBE_BYPASS;
					end else begin
						xf_r <= xf_r - 9'h001;
					end
				end
				default: begin
					fade_r <= DBE_BYPASS;
				end
			endcase
		end
	end

	// ----------------------------------------
	// output stage
	// ----------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			out_l_r <= 16'sh0000;
			out_r_r <= 16'sh0000;
			out_sub_r <= 16'sh0000;
		end else if (sample_stb) begin
			out_sub_r <= sub16;
			if (mix_r) begin
				out_l_r <= sat16(32'(in_l) + 32'(sub16));
				out_r_r <= sat16(32'(in_r) + 32'(sub16));
			end else begin
				out_l_r <= in_l;
				out_r_r <= in_r;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			valid_r <= 1'b0;
		end else begin
			valid_r <= sample_stb;
		end
	end

	assign out_l = out_l_r;
	assign out_r = out_r_r;
	assign out_sub = out_sub_r;
	assign out_valid = valid_r;
	assign hrdata = hrdata_r;
	assign hreadyout = hready_r;
	assign hresp = 1'b0;
endmodule
`default_nettype wire

// ### verification/dbe_src.sv
// Purpose: upstream sample source standing in for the equalizer output
// Assumes: one strobe every PER clock cycles once reset is released
// Notes: samples change only at a strobe, as a real sample stream does
`timescale 1ns/1ps
`default_nettype none
module dbe_src #(
	parameter int PER = 4
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic signed [15:0] l_val,
	input wire logic signed [15:0] r_val,
	output logic sample_stb,
	output logic signed [15:0] in_l,
	output logic signed [15:0] in_r
);
	logic [7:0] cnt_r;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_r <= 8'h00;
			sample_stb <= 1'b0;
		end else begin
			cnt_r <= (cnt_r == 8'(PER - 1)) ? 8'h00 : cnt_r + 8'h01;
			sample_stb <= (cnt_r == 8'h00);
		end
	end
	always_ff @(posedge hclk) begin
		if (cnt_r == 8'h00) begin
			in_l <= l_val;
			in_r <= r_val;
		end
	end
endmodule
`default_nettype wire

// ### verification/dbe_top_sva.sv
// Purpose: port checker of the bass enhancer top
// Assumes: single slave, hready tied to hreadyout
// Notes: bound into every dbe_top instance
`timescale 1ns/1ps
`default_nettype none
module dbe_top_sva (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic sample_stb,
	input wire logic signed [15:0] out_l,
	input wire logic signed [15:0] out_r,
	input wire logic signed [15:0] out_sub,
	input wire logic out_valid
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_rd_taken;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	sequence s_rd_done;
		!hreadyout ##1 hreadyout;
	endsequence
	property p_rd_wait;
		s_rd_taken |=> s_rd_done;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
	property p_wr_nowait;
		hsel && hready && htrans[1] && hwrite |=> hreadyout;
	endproperty
	a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
	property p_rdy_cause;
		$fell(hreadyout) |-> $past(hsel && htrans[1] && !hwrite);
	endproperty
	a_rdy_cause: assert property (p_rdy_cause) else $error("stall without read");
	property p_hrdata_hold;
		hreadyout && $past(hreadyout) |-> $stable(hrdata);
	endproperty
	a_hrdata_hold: assert property (p_hrdata_hold) else $error("read data moved");
	property p_okay;
		hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	property p_valid;
		sample_stb |=> out_valid;
	endproperty
	a_valid: assert property (p_valid) else $error("no output after strobe");
	property p_novalid;
		!sample_stb |=> !out_valid;
	endproperty
	a_novalid: assert property (p_novalid) else $error("output without strobe");
	property p_hold;
		!sample_stb |=> $stable(out_l) && $stable(out_r) && $stable(out_sub);
	endproperty
	a_hold: assert property (p_hold) else $error("audio moved between strobes");
endmodule
bind dbe_top dbe_top_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
	.sample_stb(sample_stb), .out_l(out_l), .out_r(out_r), .out_sub(out_sub),
	.out_valid(out_valid));
`default_nettype wire

// ### verification/dynamic_bass_enhancer_test.sv
// Purpose: register and audio tests of the bass enhancer
// Assumes: source strobes every 4 cycles
// Notes: register values from the hand-over map
`timescale 1ns/1ps
`default_nettype none
module dynamic_bass_enhancer_test
	import dbe_pkg::*;
;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hreadyout;
	logic sample_stb, out_valid;
	logic signed [15:0] in_l, in_r, out_l, out_r, out_sub;
	logic signed [15:0] l_val = 16'sd1000;
	logic signed [15:0] r_val = -16'sd1000;
	logic [31:0] v;
	int n_fail = 0;
	int compares = 0;
	logic [7:0] ra [7] = '{DBE_CTRL_A, DBE_STR_A, DBE_HARM_A, DBE_CF_A, DBE_LIM_A, DBE_LVL0_A,
		DBE_LVL1_A};
	logic [31:0] rv [7] = '{32'h0, 32'h0, 32'h0, 32'(DBE_CF_DEF), 32'h0, 32'(DBE_LVL_UNITY),
		32'(DBE_LVL_UNITY)};
	logic [7:0] ca [9] = '{DBE_HARM_A, DBE_HARM_A, DBE_CF_A, DBE_CF_A, DBE_CF_A, DBE_LIM_A,
		DBE_LIM_A, DBE_STR_A, DBE_CF_A};
	logic [31:0] cw [9] = '{32'h7f, 32'h32, 32'h5, 32'h3ff, 32'h12c, 32'h3f, 32'h20, 32'hff,
		32'h205};
	logic [31:0] ce [9] = '{32'h64, 32'h32, 32'h14, 32'h12c, 32'h12c, 32'h20, 32'h20, 32'hff,
		32'h12c};
	always #50 hclk = ~hclk;
	dbe_src u_src (.hclk(hclk), .hresetn(hresetn), .l_val(l_val), .r_val(r_val),
		.sample_stb(sample_stb), .in_l(in_l), .in_r(in_r));
	dbe_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(), .sample_stb(sample_stb), .in_l(in_l), .in_r(in_r),
		.out_l(out_l), .out_r(out_r), .out_sub(out_sub), .out_valid(out_valid));
	// ----------------------------------------
	// bus and compare tasks
	// ----------------------------------------
	task automatic ahb_go(input logic [7:0] a, input logic wr, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		v = hrdata;
		hwdata <= 32'h0;
	endtask
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %0t register %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_aud(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected %0t audio %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb_go(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		ahb_go(a, 1'b0, 32'h0);
		chk_reg(v, exp);
	endtask
	task automatic smp(input int n);
		repeat (n * 4) @(posedge hclk);
	endtask
	task automatic end_sim;
		$display("mismatches %0d compares %0d", n_fail, compares);
		if (n_fail == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
		smp(8);
		chk_aud(out_sub, 16'h0);
		chk_aud(out_l, 16'sd1000);
		chk_aud(out_r, -16'sd1000);
		wr(8'h20, 32'hffff_ffff);
		rd(8'h20, 32'h0);
		for (int i = 0; i < 9; i++) begin
			wr(ca[i], cw[i]);
			rd(ca[i], ce[i]);
		end
		wr(DBE_CF_A, 32'(DBE_CF_DEF));
		l_val <= 16'sd8000;
		r_val <= 16'sd8000;
		smp(400);
		chk_aud(16'(out_sub != 16'sh0), 16'h1);
		wr(DBE_LVL0_A, 32'h0);
		smp(8);
		chk_aud(out_sub, 16'h0);
		wr(DBE_LVL0_A, 32'(DBE_LVL_UNITY));
		wr(DBE_CTRL_A, 32'h2);
		smp(8);
		chk_aud(out_l, 16'(17'sd8000 + 17'(out_sub) > 17'sd32767 ? 17'sd32767 :
			17'sd8000 + 17'(out_sub)));
		chk_aud(out_r, 16'(17'sd8000 + 17'(out_sub) > 17'sd32767 ? 17'sd32767 :
			17'sd8000 + 17'(out_sub)));
		wr(DBE_CTRL_A, 32'h1);
		rd(DBE_STR_A, 32'(DBE_STR_MED));
		rd(DBE_HARM_A, 32'(DBE_HARM_HALF));
		rd(DBE_CF_A, 32'(DBE_CF_DEF));
		ahb_go(DBE_STAT_A, 1'b0, 32'h0);
		chk_reg({30'h0, v[1:0]}, 32'h1);
		wr(DBE_LIM_A, 32'(DBE_LIM_MAX));
		l_val <= 16'sd30000;
		r_val <= 16'sd30000;
		smp(600);
		ahb_go(DBE_STAT_A, 1'b0, 32'h0);
		chk_reg({30'h0, v[1:0]}, 32'h2);
		chk_reg(32'(v[15:8] != 8'h00), 32'h1);
		chk_aud(16'(out_sub > 16'sd2047 || out_sub < -16'sd2048), 16'h0);
		wr(DBE_CTRL_A, 32'h0);
		rd(DBE_STR_A, 32'(DBE_STR_OFF));
		rd(DBE_HARM_A, 32'(DBE_HARM_OFF));
		smp(300);
		ahb_go(DBE_STAT_A, 1'b0, 32'h0);
		chk_reg({30'h0, v[1:0]}, 32'h0);
		@(posedge hclk);
		hresetn <= 1'b0;
		@(negedge hclk);
		chk_aud(16'(out_valid), 16'h0);
		chk_aud(out_sub, 16'h0);
		@(posedge hclk);
		hresetn <= 1'b1;
		rd(DBE_LIM_A, 32'h0);
		end_sim;
	end
	initial begin
		repeat (40000) @(posedge hclk);
		n_fail++;
		end_sim;
	end
endmodule
`default_nettype wire
